/* File: inc/fds_pkg.sv */
// Constants, channel map, register map and types of the fault deglitch monitor
package fds_pkg;

    localparam int CLK_MHZ       = 40;
    localparam int CLK_PERIOD_NS = 25;

    // Times as printed (nominal unless noted)
    localparam int T_DG200_US  = 200;
    localparam int T_DG500_US  = 500;
    localparam int T_DG100_US  = 100;
    localparam int T_ZC_US     = 10;
    localparam int T_MODE_NS   = 3000;
    localparam int T_THR_NS    = 200;
    localparam int T_PHMIN_US  = 10;
    localparam int T_RECOV_US  = 14000;
    localparam int T_PWRON_US  = 12000;
    localparam int T_BLANK_US  = 336;

    localparam int DG200_CYC = T_DG200_US * CLK_MHZ;
    localparam int DG500_CYC = T_DG500_US * CLK_MHZ;
    localparam int DG100_CYC = T_DG100_US * CLK_MHZ;
    localparam int ZC_CYC    = T_ZC_US * CLK_MHZ;
    localparam int MODE_CYC  = T_MODE_NS / CLK_PERIOD_NS;
    localparam int THR_CYC   = T_THR_NS / CLK_PERIOD_NS;
    localparam int PHMIN_CYC = T_PHMIN_US * CLK_MHZ;
    localparam int RECOV_CYC = T_RECOV_US * CLK_MHZ;
    localparam int PWRON_CYC = T_PWRON_US * CLK_MHZ;
    localparam int BLANK_CYC = T_BLANK_US * CLK_MHZ;

    localparam int CNT_W = 20;
    localparam int PH_W  = 10;

    // Gain code window
    localparam logic [7:0] GAIN_HIGH_LIM = 8'hfb;
    localparam logic [7:0] GAIN_LOW_LIM  = 8'h04;
    localparam logic [1:0] PH_VIOL_LAST  = 2'h2;

    // Deglitch channels
    localparam int CH_VCC_OV    = 0;
    localparam int CH_VCC_UV    = 1;
    localparam int CH_RAIL_OV   = 2;
    localparam int CH_LC_AMP    = 3;
    localparam int CH_AGC_TGL   = 4;
    localparam int CH_IN0       = 5;
    localparam int CH_IN_ALL    = 9;
    localparam int CH_LPF       = 10;
    localparam int CH_OUT_OOR   = 11;
    localparam int CH_OUT_SHORT = 12;
    localparam int CH_OUT_CM    = 13;
    localparam int CH_OUT_ZC    = 14;
    localparam int CH_AGC_ZC    = 15;
    localparam int CH_GAIN      = 16;
    localparam int CH_THR_FAST  = 17;
    localparam int CH_THR_SLOW  = 18;
    localparam int NCH          = 19;

    // Fault vector bit positions
    localparam int FV_PHASE = 13;
    localparam int FV_TSD   = 14;
    localparam int FV_W     = 15;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_FAULT = 8'h04;
    localparam logic [7:0] REG_LATCH = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0c;
    localparam logic [7:0] REG_GAIN  = 8'h10;
    localparam int CTRL_SUPPLY5V = 0;
    localparam logic CTRL_RESET  = 1'b1;

    typedef enum logic [3:0] {
        ST_PWRON  = 4'b0001,
        ST_NORMAL = 4'b0010,
        ST_FAULT  = 4'b0100,
        ST_DIAG   = 4'b1000
    } fds_state_t;

    typedef struct packed {
        logic       vccOv;
        logic       vccUv;
        logic       railOv;
        logic       lcAmp;
        logic [3:0] inOor;
        logic       lpfOor;
        logic       outOor;
        logic       outShort;
        logic       outCm;
        logic       outZc;
        logic       agcZc;
        logic       thrFast;
        logic       thrSlow;
        logic       tempAbove;
        logic       tempBelow;
    } fds_raw_t;

endpackage : fds_pkg

/* File: verilog/fds_monitor.sv */
// Fault deglitch monitor: qualifies raw flags and controls output release
`timescale 1ns/1ps
`default_nettype none
module fds_monitor
    import fds_pkg::*;
#(
    parameter int DG200_LIM = DG200_CYC,
    parameter int DG500_LIM = DG500_CYC,
    parameter int RECOV_LIM = RECOV_CYC,
    parameter int PWRON_LIM = PWRON_CYC,
    parameter int BLANK_LIM = BLANK_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Raw comparator and monitor flags
    input  wire fds_raw_t    rawFlags,
    input  wire logic        sinZeroCross,
    input  wire logic        cosZeroCross,
    input  wire logic [7:0]  gainCode,
    input  wire logic        agcPinCmp,
    // Sensor output pin enable and status outputs
    output logic             sensorOutputPinsOe_n,
    output logic             faultActive,
    output logic             agcAutoMode,
    output logic             thrFastCrossed,
    output logic             thrSlowCrossed,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    function automatic logic [CNT_W-1:0] dgNext(
        input logic [CNT_W-1:0] cnt,
        input logic             raw,
        input logic [CNT_W-1:0] lim
    );
        if (!raw)
            return '0;
        else if (cnt >= lim)
            return lim;
        else
            return cnt + 1'b1;
    endfunction : dgNext

    localparam logic [CNT_W-1:0] L200   = CNT_W'(DG200_LIM);
    localparam logic [CNT_W-1:0] L500   = CNT_W'(DG500_LIM);
    localparam logic [CNT_W-1:0] L100   = CNT_W'(DG100_CYC);
    localparam logic [CNT_W-1:0] LZC    = CNT_W'(ZC_CYC);
    localparam logic [CNT_W-1:0] LTHR   = CNT_W'(THR_CYC);
    localparam logic [CNT_W-1:0] LMODE  = CNT_W'(MODE_CYC);
    localparam logic [CNT_W-1:0] LRECOV = CNT_W'(RECOV_LIM);
    localparam logic [CNT_W-1:0] LPWRON = CNT_W'(PWRON_LIM);
    localparam logic [CNT_W-1:0] LBLANK = CNT_W'(BLANK_LIM);
    localparam logic [PH_W-1:0]  LPHMIN = PH_W'(PHMIN_CYC);

    fds_state_t          state_r;
    fds_state_t          state_nxt;
    logic [CNT_W-1:0]    stateCnt_r;
    logic [CNT_W-1:0]    blankCnt_r;
    logic [CNT_W-1:0]    dgCnt_r [NCH];
    logic [NCH-1:0]      dgRaw;
    logic [NCH-1:0]      dgQual;
    logic [CNT_W-1:0]    dgLim [NCH];
    logic [CNT_W-1:0]    modeCnt_r;
    logic                modeFilt_r;
    logic                modeLatched_r;
    logic                tsd_r;
    logic                supply5v_r;
    logic [FV_W-1:0]     latch_r;
    logic [PH_W-1:0]     phTimer_r;
    logic [1:0]          phViol_r;
    logic                phaseQual_r;
    logic                lastWasCos_r;
    logic                haveCross_r;
    logic                oe_n_r;
    logic                fault_r;
    logic                auto_r;
    logic                thrF_r;
    logic                thrS_r;
    logic [31:0]         datOut_r;
    logic                ack_r;

    // Named decodes
    wire inNormal   = (state_r == ST_NORMAL);
    wire blanking   = (blankCnt_r != '0);
    wire outFltOk   = inNormal && !blanking;
    wire gainCond   = modeLatched_r &&
                      ((gainCode >= GAIN_HIGH_LIM) ||
                       (gainCode <= GAIN_LOW_LIM));
    wire agcToggle  = inNormal && (agcPinCmp != modeLatched_r);
    wire modeDiff   = (agcPinCmp != modeFilt_r);
    wire anyCross   = sinZeroCross || cosZeroCross;
    wire crossOther = haveCross_r &&
                      ((sinZeroCross && lastWasCos_r) ||
                       (cosZeroCross && !lastWasCos_r));
    wire phViol     = inNormal && ((sinZeroCross && cosZeroCross) ||
                      (crossOther && (phTimer_r < LPHMIN)));
    wire phGood     = crossOther && !phViol;

    // Raw conditions per channel; output-pin faults masked while blanked
    assign dgRaw[CH_VCC_OV]    = rawFlags.vccOv;
    assign dgRaw[CH_VCC_UV]    = rawFlags.vccUv && supply5v_r;
    assign dgRaw[CH_RAIL_OV]   = rawFlags.railOv;
    assign dgRaw[CH_LC_AMP]    = rawFlags.lcAmp;
    assign dgRaw[CH_AGC_TGL]   = agcToggle;
    assign dgRaw[CH_IN0+3:CH_IN0] = rawFlags.inOor;
    assign dgRaw[CH_IN_ALL]    = |dgQual[CH_IN0+3:CH_IN0];
    assign dgRaw[CH_LPF]       = rawFlags.lpfOor;
    assign dgRaw[CH_OUT_OOR]   = rawFlags.outOor && outFltOk;
    assign dgRaw[CH_OUT_SHORT] = rawFlags.outShort && outFltOk;
    assign dgRaw[CH_OUT_CM]    = rawFlags.outCm && outFltOk;
    assign dgRaw[CH_OUT_ZC]    = rawFlags.outZc && outFltOk;
    assign dgRaw[CH_AGC_ZC]    = rawFlags.agcZc;
    assign dgRaw[CH_GAIN]      = gainCond;
    assign dgRaw[CH_THR_FAST]  = rawFlags.thrFast;
    assign dgRaw[CH_THR_SLOW]  = rawFlags.thrSlow;

    assign dgLim[CH_VCC_OV]    = L200;
    assign dgLim[CH_VCC_UV]    = L200;
    assign dgLim[CH_RAIL_OV]   = L200;
    assign dgLim[CH_LC_AMP]    = L200;
    assign dgLim[CH_AGC_TGL]   = L500;
    assign dgLim[CH_IN0]       = L200;
    assign dgLim[CH_IN0+1]     = L200;
    assign dgLim[CH_IN0+2]     = L200;
    assign dgLim[CH_IN0+3]     = L200;
    assign dgLim[CH_IN_ALL]    = L200;
    assign dgLim[CH_LPF]       = L200;
    assign dgLim[CH_OUT_OOR]   = L200;
    assign dgLim[CH_OUT_SHORT] = L500;
    assign dgLim[CH_OUT_CM]    = L100;
    assign dgLim[CH_OUT_ZC]    = LZC;
    assign dgLim[CH_AGC_ZC]    = LZC;
    assign dgLim[CH_GAIN]      = L200;
    assign dgLim[CH_THR_FAST]  = LTHR;
    assign dgLim[CH_THR_SLOW]  = LTHR;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gDeglitch
            assign dgQual[g] = dgRaw[g] && (dgCnt_r[g] == dgLim[g]);
            always_ff @(posedge clk) begin
                if (!rst_n)
                    dgCnt_r[g] <= '0;
                else
                    dgCnt_r[g] <= dgNext(dgCnt_r[g], dgRaw[g], dgLim[g]);
            end
        end
    endgenerate

    // Qualified fault vector; raw regulator level alone never appears here
    wire [FV_W-1:0] faultVec = {
        tsd_r, phaseQual_r, dgQual[CH_GAIN], dgQual[CH_AGC_ZC],
        dgQual[CH_OUT_ZC], dgQual[CH_OUT_CM], dgQual[CH_OUT_SHORT],
        dgQual[CH_OUT_OOR], dgQual[CH_LPF], dgQual[CH_IN_ALL],
        dgQual[CH_AGC_TGL], dgQual[CH_LC_AMP], dgQual[CH_RAIL_OV],
        dgQual[CH_VCC_UV], dgQual[CH_VCC_OV]};
    wire anyFault = |faultVec;
    wire holdFault = |(faultVec & ~(FV_W'(1) << FV_PHASE));

    // Gain-mode pin filter, frozen once normal operation has begun
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modeCnt_r  <= '0;
            modeFilt_r <= 1'b0;
        end else if (state_r == ST_PWRON) begin
            modeCnt_r  <= (modeCnt_r == LMODE) ? '0 :
                          dgNext(modeCnt_r, modeDiff, LMODE);
            if (modeCnt_r == LMODE && modeDiff)
                modeFilt_r <= agcPinCmp;
        end
    end

    // Thermal hysteresis; a new overheat beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n)
            tsd_r <= 1'b0;
        else if (rawFlags.tempAbove)
            tsd_r <= 1'b1;
        else if (rawFlags.tempBelow)
            tsd_r <= 1'b0;
    end

    // Phase balance: time since the last crossing, counted in normal state
    always_ff @(posedge clk) begin
        if (!rst_n || !inNormal) begin
            phTimer_r    <= '0;
            phViol_r     <= '0;
            haveCross_r  <= 1'b0;
            lastWasCos_r <= 1'b0;
        end else begin
            phTimer_r <= anyCross ? '0 :
                         (phTimer_r == LPHMIN ? LPHMIN : phTimer_r + 1'b1);
            if (anyCross) begin
                haveCross_r  <= 1'b1;
                lastWasCos_r <= cosZeroCross;
            end
            if (phViol)
                phViol_r <= (phViol_r == PH_VIOL_LAST) ? '0 :
                            phViol_r + 1'b1;
            else if (phGood)
                phViol_r <= '0;
        end
    end

    // Phase fault stays until the fault state is left
    always_ff @(posedge clk) begin
        if (!rst_n)
            phaseQual_r <= 1'b0;
        else if (phViol && phViol_r == PH_VIOL_LAST)
            phaseQual_r <= 1'b1;
        else if (state_r == ST_FAULT && !holdFault)
            phaseQual_r <= 1'b0;
    end

    // Supervisor state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_PWRON:  if (stateCnt_r == LPWRON) state_nxt = ST_NORMAL;
            ST_NORMAL: if (anyFault) state_nxt = ST_FAULT;
            ST_FAULT:  if (!holdFault) state_nxt = ST_DIAG;
            ST_DIAG: begin
                if (holdFault)
                    state_nxt = ST_FAULT;
                else if (stateCnt_r == LRECOV)
                    state_nxt = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r    <= ST_PWRON;
            stateCnt_r <= '0;
        end else begin
            state_r    <= state_nxt;
            stateCnt_r <= (state_nxt != state_r) ? '0 : stateCnt_r + 1'b1;
        end
    end

    // Blanking of output-pin faults after each release of the outputs
    always_ff @(posedge clk) begin
        if (!rst_n)
            blankCnt_r <= '0;
        else if (state_nxt == ST_NORMAL && state_r != ST_NORMAL)
            blankCnt_r <= LBLANK;
        else if (blankCnt_r != '0)
            blankCnt_r <= blankCnt_r - 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            modeLatched_r <= 1'b0;
        else if (state_r == ST_PWRON && state_nxt == ST_NORMAL)
            modeLatched_r <= modeFilt_r;
    end

    // Registered pin controls and status outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_n_r  <= 1'b1;
            fault_r <= 1'b0;
            auto_r  <= 1'b0;
            thrF_r  <= 1'b0;
            thrS_r  <= 1'b0;
        end else begin
            oe_n_r  <= (state_nxt != ST_NORMAL);
            fault_r <= (state_nxt == ST_FAULT);
            auto_r  <= modeLatched_r;
            thrF_r  <= dgQual[CH_THR_FAST];
            thrS_r  <= dgQual[CH_THR_SLOW];
        end
    end

    assign sensorOutputPinsOe_n = oe_n_r;
    assign faultActive          = fault_r;
    assign agcAutoMode          = auto_r;
    assign thrFastCrossed       = thrF_r;
    assign thrSlowCrossed       = thrS_r;

    // Wishbone slave: one wait state, unmapped reads return zero
    wire        wbReq    = wb_cyc_i && wb_stb_i && !ack_r;
    wire        wbWr     = wbReq && wb_we_i;
    wire        wrCtrl   = wbWr && wb_adr_i == REG_CTRL && wb_sel_i[0];
    wire        wrLatch  = wbWr && wb_adr_i == REG_LATCH;
    wire [FV_W-1:0] clrMask = {wb_sel_i[1] ? wb_dat_i[FV_W-1:8] : 7'h00,
                               wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    wire [31:0] rdMux =
        (wb_adr_i == REG_CTRL)  ? {31'h0, supply5v_r} :
        (wb_adr_i == REG_FAULT) ? {17'h0, faultVec} :
        (wb_adr_i == REG_LATCH) ? {17'h0, latch_r} :
        (wb_adr_i == REG_STATE) ? {25'h0, thrS_r, thrF_r, modeLatched_r,
                                   state_r} :
        (wb_adr_i == REG_GAIN)  ? {24'h0, gainCode} : 32'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r      <= 1'b0;
            datOut_r   <= '0;
            supply5v_r <= CTRL_RESET;
        end else begin
            ack_r    <= wbReq;
            datOut_r <= wbReq ? rdMux : '0;
            if (wrCtrl)
                supply5v_r <= wb_dat_i[CTRL_SUPPLY5V];
        end
    end

    // Sticky fault record; a new fault wins over a write-one clear
    always_ff @(posedge clk) begin
        if (!rst_n)
            latch_r <= '0;
        else
            latch_r <= (latch_r & ~(wrLatch ? clrMask : '0)) | faultVec;
    end

    assign wb_dat_o = datOut_r;
    assign wb_ack_o = ack_r;

    // Checks
    phaseViol_a: assert property (@(posedge clk) disable iff (!rst_n)
        phViol && phViol_r < PH_VIOL_LAST |=> phViol_r == $past(phViol_r) + 2'h1)
        else $error("phase violation not counted");
    phaseThree_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(phaseQual_r) |-> $past(phViol_r) == PH_VIOL_LAST && $past(phViol))
        else $error("phase fault without three violations");
    gainRange_a: assert property (@(posedge clk) disable iff (!rst_n)
        dgQual[CH_GAIN] |-> modeLatched_r &&
            (gainCode >= 8'hfb || gainCode <= 8'h04))
        else $error("gain fault outside range condition");
    supplyDg_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dgQual[CH_VCC_OV]) && $past(rawFlags.vccOv) |->
            $past(dgCnt_r[CH_VCC_OV]) == L200 - 1'b1)
        else $error("supply fault qualified early");
    uvIgnore_a: assert property (@(posedge clk) disable iff (!rst_n)
        !supply5v_r |-> !dgQual[CH_VCC_UV])
        else $error("undervoltage qualified in 3.3 V mode");
    // Run length of the short condition, kept apart from the deglitch counter
    logic [CNT_W-1:0] shortRun_r;
    always_ff @(posedge clk) begin
        if (!rst_n || !(rawFlags.outShort && outFltOk))
            shortRun_r <= '0;
        else if (shortRun_r != '1)
            shortRun_r <= shortRun_r + 1'b1;
    end
    shortDg_a: assert property (@(posedge clk) disable iff (!rst_n)
        dgQual[CH_OUT_SHORT] |-> shortRun_r >= L500)
        else $error("output short qualified early");
    blankOut_a: assert property (@(posedge clk) disable iff (!rst_n)
        blanking |-> !dgQual[CH_OUT_OOR] && !dgQual[CH_OUT_SHORT] &&
            !dgQual[CH_OUT_CM] && !dgQual[CH_OUT_ZC])
        else $error("output fault during blanking");
    pwrRelease_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(oe_n_r) && $past(state_r) == ST_PWRON |->
            $past(stateCnt_r) == LPWRON)
        else $error("outputs released before power-on interval");
    faultHiz_a: assert property (@(posedge clk) disable iff (!rst_n)
        inNormal && anyFault |=> oe_n_r && fault_r)
        else $error("outputs driven with qualified fault");
    tsdHyst_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(tsd_r) |-> $past(rawFlags.tempBelow) && !$past(rawFlags.tempAbove))
        else $error("thermal fault cleared without cooling");
    tsdSet_a: assert property (@(posedge clk) disable iff (!rst_n)
        rawFlags.tempAbove |=> tsd_r)
        else $error("thermal fault not raised");
    recovWait_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(oe_n_r) && $past(state_r) == ST_DIAG |->
            $past(stateCnt_r) == LRECOV)
        else $error("outputs released before recovery interval");
    modeFrozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(modeLatched_r) |-> $past(state_r) == ST_PWRON)
        else $error("gain mode changed after power-on");

endmodule : fds_monitor
`default_nettype wire

/* File: verification/fds_adc_model.sv */
// Host ADC model that samples the sensor outputs only while they are driven
`timescale 1ns/1ps
`default_nettype none
module fds_adc_model (
    // Clock
    input  wire logic clk,
    // Sensor output pin enable
    input  wire logic sensorOutputPinsOe_n,
    // Samples taken
    output var  int   samples
);
    // A hi-Z output carries no position, so those slots are not sampled
    initial samples = 0;
    always @(posedge clk) begin
        if (sensorOutputPinsOe_n === 1'b0) begin
            samples <= samples + 1;
        end
    end
endmodule : fds_adc_model
`default_nettype wire

/* File: verification/tb_fault_deglitch_monitor.sv */
// Self-checking bench for the fault deglitch monitor
`timescale 1ns/1ps
`default_nettype none
module tb_fault_deglitch_monitor;
    import fds_pkg::*;
    localparam int PWR = 200;
    localparam int REC = 100;
    typedef struct {
        fds_raw_t   raw;
        logic [7:0] gain;
        logic       pin;
        int         lim;
        int         fbit;
    } fds_row_t;
    logic clk, rst_n, sinZc, cosZc, agcPin, oeN, fault, autoMode, thrF, thrS;
    logic cycI, stbI, weI, ackO;
    fds_raw_t    rawFlags;
    logic [7:0]  gain, adr;
    logic [31:0] datI, datO, q;
    int n_errors = 0;
    int checked = 0;
    int samples, n, m;
    // Raw flag, gain code, mode pin, quiet span, expected fault bit
    fds_row_t rows [14] = '{
        '{18'h20000, 8'h80, 1'b1, 20, 0}, '{18'h10000, 8'h80, 1'b1, 20, 1},
        '{18'h08000, 8'h80, 1'b1, 20, 2}, '{18'h04000, 8'h80, 1'b1, 20, 3},
        '{18'h02000, 8'h80, 1'b1, 40, 5}, '{18'h00200, 8'h80, 1'b1, 20, 6},
        '{18'h00100, 8'h80, 1'b1, 20, 7}, '{18'h00080, 8'h80, 1'b1, 50, 8},
        '{18'h00040, 8'h80, 1'b1, 4000, 9}, '{18'h00020, 8'h80, 1'b1, 400, 10},
        '{18'h00010, 8'h80, 1'b1, 400, 11}, '{18'h0, 8'hfb, 1'b1, 20, 12},
        '{18'h0, 8'h04, 1'b1, 20, 12}, '{18'h0, 8'h80, 1'b0, 50, 4}};

    fds_monitor #(.DG200_LIM(20), .DG500_LIM(50), .RECOV_LIM(REC),
        .PWRON_LIM(PWR), .BLANK_LIM(30)) i_dut (
        .clk(clk), .rst_n(rst_n), .rawFlags(rawFlags), .sinZeroCross(sinZc),
        .cosZeroCross(cosZc), .gainCode(gain), .agcPinCmp(agcPin),
        .sensorOutputPinsOe_n(oeN), .faultActive(fault), .agcAutoMode(autoMode),
        .thrFastCrossed(thrF), .thrSlowCrossed(thrS), .wb_cyc_i(cycI),
        .wb_stb_i(stbI), .wb_we_i(weI), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ackO));
    fds_adc_model i_adc (.clk(clk), .sensorOutputPinsOe_n(oeN), .samples(samples));

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge clk);
        cycI <= 1'b1; stbI <= 1'b1; weI <= w; adr <= a; datI <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ackO !== 1'b1 && n < 20);
        q = datO;
        chk(ackO === 1'b1, "no bus ack");
        cycI <= 1'b0; stbI <= 1'b0;
    endtask : wb
    task automatic waitSig(input logic onFault, input logic v, input int mx);
        n = 0;
        while ((onFault ? fault : oeN) !== v && n < mx) begin
            @(posedge clk);
            n++;
        end
    endtask : waitSig
    task automatic ph(input logic s, input logic c, input int gap);
        sinZc <= s; cosZc <= c;
        cyc(1);
        sinZc <= 1'b0; cosZc <= 1'b0;
        cyc(gap);
    endtask : ph
    task automatic powerUp;
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
        chk(oeN === 1'b1 && fault === 1'b0, "reset outputs");
        cyc(PWR - 20);
        chk(oeN === 1'b1, "released early");
        waitSig(0, 0, 60);
        chk(n < 60, "never released");
        cyc(1);
        chk(autoMode === 1'b1, "gain mode");
        $display("power-up done");
    endtask : powerUp
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run is under ten thousand cycles
    initial begin
        cyc(60000);
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end
    initial begin
        rst_n = 1'b0; rawFlags = '0; sinZc = 1'b0; cosZc = 1'b0; gain = 8'h80;
        agcPin = 1'b1; cycI = 1'b0; stbI = 1'b0; weI = 1'b0; adr = 8'h0;
        datI = 32'h0;
        powerUp();
        wb(0, 8'h40, 32'h0);
        chk(q === 32'h0, "unmapped read");
        foreach (rows[i]) begin
            cyc(40);
            rawFlags <= rows[i].raw; gain <= rows[i].gain; agcPin <= rows[i].pin;
            cyc(rows[i].lim);
            chk(fault === 1'b0, "fault too early");
            waitSig(1, 1, 3);
            chk(n < 3 && oeN === 1'b1, "no fault or no hi-z");
            wb(0, REG_LATCH, 32'h0);
            chk(q === 32'h1 << rows[i].fbit, "fault bit");
            rawFlags <= '0; gain <= 8'h80; agcPin <= 1'b1;
            wb(1, REG_LATCH, 32'h7fff);
            cyc(50);
            chk(oeN === 1'b1, "recovered too fast");
            waitSig(0, 0, REC);
            chk(n < REC, "no recovery");
            $display("row %0d done", i);
        end
        wb(1, REG_CTRL, 32'h0);
        wb(0, REG_CTRL, 32'h0);
        chk(q === 32'h0, "supply mode not written");
        rawFlags <= 18'h10000;
        cyc(60);
        chk(fault === 1'b0, "undervoltage in 3v3 mode");
        rawFlags <= '0;
        wb(1, REG_CTRL, 32'h1);
        $display("supply mode done");
        ph(1, 0, 10); ph(0, 1, 10); ph(1, 0, 500); ph(0, 1, 10);
        ph(1, 0, 10); ph(0, 1, 20);
        chk(fault === 1'b0, "phase count not reset");
        ph(1, 0, 0);
        waitSig(1, 1, 10);
        chk(n < 10, "phase fault missing");
        wb(0, REG_LATCH, 32'h0);
        chk(q === 32'h1 << FV_PHASE, "phase fault bit");
        waitSig(0, 0, REC + 60);
        chk(n < REC + 60, "no phase recovery");
        $display("phase done");
        rawFlags <= 18'h00002;
        waitSig(1, 1, 10);
        chk(n < 10, "thermal fault missing");
        m = samples;
        rawFlags <= '0;
        cyc(REC + 50);
        chk(fault === 1'b1, "thermal cleared early");
        chk(samples == m, "outputs driven in fault");
        wb(0, REG_FAULT, 32'h0);
        chk(q === 32'h1 << FV_TSD, "thermal fault bit");
        rawFlags <= 18'h00001;
        waitSig(0, 0, REC + 60);
        chk(n < REC + 60, "thermal never cleared");
        rawFlags <= 18'h0000c;
        cyc(6);
        chk(thrF === 1'b0 && thrS === 1'b0, "threshold early");
        cyc(6);
        chk(thrF === 1'b1 && thrS === 1'b1, "threshold missing");
        chk(samples > m, "outputs not driven after recovery");
        rawFlags <= '0;
        $display("thermal and thresholds done");
        powerUp();
        print_verdict();
    end
endmodule : tb_fault_deglitch_monitor
`default_nettype wire
